// file: bench/tb_top.sv
// Self-checking bench for the irq and prescaler control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cipc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic ext_pin, tclk_pin, wdt_base_tick, wake, irq_req, wdt_tick;
    logic [7:0] paddr, port_b_pins, port_pullup_en, timer_a_count;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] periph_events;
    int n_mismatch, compares, per;

    cipc_core u_cipc_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
        .timer_a_clock_pin(tclk_pin), .wdt_base_tick(wdt_base_tick),
        .port_b_pins(port_b_pins), .low_power_wake_source(wake),
        .periph_events(periph_events), .port_pullup_en(port_pullup_en),
        .wdt_tick(wdt_tick), .timer_a_count(timer_a_count),
        .irq_req(irq_req)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; read data taken at the access edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        err = pslverr;
        rd = prdata;
        if (i == 20) begin
            n_mismatch++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask

    // Cycles between two successive count increments
    task automatic period(output int p);
        logic [7:0] c;
        int i;
        @(posedge pclk);
        c = timer_a_count;
        for (i = 0; i < 600 && timer_a_count === c; i++) @(posedge pclk);
        c = timer_a_count;
        for (p = 0; p < 600 && timer_a_count === c; p++) @(posedge pclk);
    endtask

    // Watchdog ticks seen over eight base ticks
    task automatic wdt_count(input logic [7:0] opt, output int n);
        wr(CIPC_OFF_OPTION, opt);
        n = 0;
        repeat (8) begin
            wdt_base_tick <= 1'b1;
            @(posedge pclk);
            n += int'(wdt_tick);
            wdt_base_tick <= 1'b0;
            @(posedge pclk);
        end
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; ext_pin = 1'b0;
        tclk_pin = 1'b0; wdt_base_tick = 1'b0; wake = 1'b0;
        port_b_pins = 8'h00; periph_events = 7'h00;
        n_mismatch = 0; compares = 0;
        cyc(4);
        presetn <= 1'b1;
        cyc(1);
        rdc(CIPC_OFF_OPTION, 8'hFF);
        rdc(CIPC_OFF_INTCTL, 8'h00);
        rdc(CIPC_OFF_PIEA, 8'h00);
        wr(CIPC_OFF_PIEA, 8'hFF);
        rdc(CIPC_OFF_PIEA, 8'h7F);
        xfer(8'h1C, 1'b0, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Pull-ups
        wr(CIPC_OFF_LATCH, 8'hA5);
        chk(port_pullup_en, 8'h00);
        wr(CIPC_OFF_OPTION, 8'h68);
        cyc(2);
        chk(port_pullup_en, 8'hA5);
        // External pin edges with all enables off, then the pin enable and the global enable
        wr(CIPC_OFF_PIEA, 8'h00);
        ext_pin <= 1'b1;
        cyc(4);
        rdc(CIPC_OFF_INTCTL, 8'h02);
        wr(CIPC_OFF_INTCTL, 8'h00);
        ext_pin <= 1'b0;
        cyc(4);
        rdc(CIPC_OFF_INTCTL, 8'h00);
        wr(CIPC_OFF_OPTION, 8'h28);
        ext_pin <= 1'b1;
        cyc(4);
        rdc(CIPC_OFF_INTCTL, 8'h00);
        ext_pin <= 1'b0;
        cyc(4);
        rdc(CIPC_OFF_INTCTL, 8'h02);
        chk(irq_req, 1'b0);
        wr(CIPC_OFF_INTCTL, 8'h12);
        cyc(3);
        chk(irq_req, 1'b0);
        wr(CIPC_OFF_INTCTL, 8'h92);
        cyc(3);
        chk(irq_req, 1'b1);
        wr(CIPC_OFF_INTCTL, 8'h90);
        cyc(3);
        chk(irq_req, 1'b0);
        // Peripheral source behind the peripheral gate
        wr(CIPC_OFF_PIRA, 8'h00);
        wr(CIPC_OFF_PIEA, 8'h40);
        periph_events <= 7'h40;
        cyc(1);
        periph_events <= 7'h00;
        cyc(3);
        rdc(CIPC_OFF_PIRA, 8'h40);
        cyc(3);
        chk(irq_req, 1'b0);
        wr(CIPC_OFF_INTCTL, 8'hC0);
        cyc(3);
        chk(irq_req, 1'b1);
        wr(CIPC_OFF_PIRA, 8'h00);
        cyc(3);
        chk(irq_req, 1'b0);
        // Port change with per-pin enables and the wake source
        wr(CIPC_OFF_INTCTL, 8'h00);
        wr(CIPC_OFF_PINCHG, 8'h01);
        port_b_pins <= 8'h02;
        cyc(4);
        rdc(CIPC_OFF_INTCTL, 8'h00);
        port_b_pins <= 8'h03;
        cyc(4);
        rdc(CIPC_OFF_INTCTL, 8'h01);
        wr(CIPC_OFF_INTCTL, 8'h00);
        wake <= 1'b1;
        cyc(1);
        wake <= 1'b0;
        cyc(3);
        rdc(CIPC_OFF_INTCTL, 8'h01);
        wr(CIPC_OFF_INTCTL, 8'h00);
        wr(CIPC_OFF_STATUS, 8'h00);
        // Internal clock, prescaler rates
        for (int r = 0; r < 3; r++) begin
            wr(CIPC_OFF_OPTION, 8'(r));
            period(per);
            chk(per, 32'(2 << r));
        end
        wr(CIPC_OFF_OPTION, 8'h08);
        period(per);
        chk(per, 32'h1);
        // External clock pin edges
        wr(CIPC_OFF_OPTION, 8'h38);
        wr(CIPC_OFF_STATUS, 8'h00);
        cyc(4);
        chk(timer_a_count, 8'h00);
        tclk_pin <= 1'b1;
        cyc(4);
        chk(timer_a_count, 8'h00);
        tclk_pin <= 1'b0;
        cyc(4);
        chk(timer_a_count, 8'h01);
        wr(CIPC_OFF_OPTION, 8'h28);
        tclk_pin <= 1'b1;
        cyc(4);
        chk(timer_a_count, 8'h02);
        // Rollover sets the sticky overflow flag
        wr(CIPC_OFF_STATUS, 8'hFF);
        wr(CIPC_OFF_INTCTL, 8'h00);
        rdc(CIPC_OFF_INTCTL, 8'h00);
        tclk_pin <= 1'b0;
        cyc(1);
        tclk_pin <= 1'b1;
        cyc(4);
        chk(timer_a_count, 8'h00);
        rdc(CIPC_OFF_INTCTL, 8'h04);
        // Watchdog divide when it owns the prescaler, else undivided
        wdt_count(8'h29, per);
        chk(per, 32'h4);
        wdt_count(8'h21, per);
        chk(per, 32'h8);
        end_of_test();
    end
endmodule
`default_nettype wire

// file: common/cipc_pkg.sv
// Package: offsets, field positions and reset values for the irq/prescaler block
package cipc_pkg;
    localparam logic [7:0] CIPC_OFF_OPTION = 8'h00;
    localparam logic [7:0] CIPC_OFF_INTCTL = 8'h04;
    localparam logic [7:0] CIPC_OFF_PIEA = 8'h08;
    localparam logic [7:0] CIPC_OFF_PIRA = 8'h0C;
    localparam logic [7:0] CIPC_OFF_STATUS = 8'h10;
    localparam logic [7:0] CIPC_OFF_LATCH = 8'h14;
    localparam logic [7:0] CIPC_OFF_PINCHG = 8'h18;
    // Option register fields
    localparam int CIPC_OPT_PULLUP_DIS = 7;
    localparam int CIPC_OPT_EDGE_SEL = 6;
    localparam int CIPC_OPT_CLK_SEL = 5;
    localparam int CIPC_OPT_SRC_EDGE = 4;
    localparam int CIPC_OPT_OWNER = 3;
    localparam int CIPC_OPT_RATE_HI = 2;
    // Core control fields
    localparam int CIPC_IC_GIE = 7;
    localparam int CIPC_IC_PERIPHERAL_IRQ_GATE = 6;
    localparam int CIPC_IC_TAE = 5;
    localparam int CIPC_IC_EXE = 4;
    localparam int CIPC_IC_PCE = 3;
    localparam int CIPC_IC_TAF = 2;
    localparam int CIPC_IC_EXF = 1;
    localparam int CIPC_IC_PCF = 0;
    localparam logic [7:0] CIPC_OPT_RESET = 8'hFF;
    localparam logic [7:0] CIPC_INTCTL_RESET = 8'h00;
    localparam logic [7:0] CIPC_PIE_RESET = 8'h00;
    localparam logic [7:0] CIPC_PIE_MASK = 8'h7F;
    localparam logic [31:0] CIPC_ZERO32 = 32'h0000_0000;
    localparam logic [7:0] CIPC_ONE8 = 8'h01;
    localparam logic [7:0] CIPC_ZERO8 = 8'h00;
    localparam logic [7:0] CIPC_ONES8 = 8'hFF;
endpackage

// file: verilog/cipc_core.sv
// Core interrupt gating and timer option control with APB registers
//
// Contract
// RL1: Pull-up disable bit 7 set turns all port pull-ups off; else latches.
// RL2: Edge select bit 6: rising pin edge when 1, falling when 0.
// RL3: Clock select bit 5: external pin when 1, instruction clock when 0.
// RL4: Source edge bit 4: falling pin edge when 1, rising when 0.
// RL5: Owner bit 3 gives prescaler to watchdog when 1, timer when 0.
// RL6: Rate field: timer divide 2^(n+1), watchdog divide 2^n.
// RL7: Software gives prescaler to watchdog for undivided timer counting.
// RL8: Flags set on their event regardless of any enable.
// RL9: Software clears flags before setting their enables.
// RL10: Global enable bit 7 permits unmasked interrupts; 0 blocks all.
// RL11: Peripheral gate bit 6 must be 1 for peripheral interrupts.
// RL12: Timer overflow flag bit 2 sets on rollover, sticks; enable bit 5.
// RL13: External pin flag bit 1 sets on chosen edge, sticks; enable bit 4.
// RL14: Port-change flag bit 0 sets on pin change, sticks; enable bit 3.
// RL15: Port change needs per-pin enables; enable also covers wake source.
// RL16: Reset leaves timer count alone; load count before clearing flag.
// RL17: Peripheral enable register holds seven enables; bit 7 reads zero.
// RL18: Request when global enable and any enabled flag pair is active.
// RL19: Peripheral flags sit in a companion register, same bit positions.
// RL20: Reset clears port-change flag; it re-sets if mismatch remains.
`timescale 1ns/1ps
`default_nettype none
module cipc_core (
    input wire logic pclk, // Clock, 25 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic ext_pin, // External interrupt pin
    input wire logic timer_a_clock_pin, // Timer0 external clock pin
    input wire logic wdt_base_tick, // Watchdog time base tick
    input wire logic [7:0] port_b_pins, // Port B pin levels
    input wire logic low_power_wake_source, // Wake-up event pulse
    input wire logic [6:0] periph_events, // Peripheral event pulses
    output logic [7:0] port_pullup_en, // Weak pull-up enables
    output logic wdt_tick, // Watchdog increment pulse
    output logic [7:0] timer_a_count, // Timer0 count
    output logic irq_req // Interrupt request
);
    import cipc_pkg::*;
    logic [7:0] opt_reg;
    logic [7:0] ictl_reg;
    logic [7:0] piea_reg;
    logic [7:0] pira_reg;
    logic [7:0] latch_reg;
    logic [7:0] pinchg_reg;
    logic [7:0] port_snap_reg;
    logic [7:0] timer_reg;
    logic ext_d_reg;
    logic [31:0] prdata_reg;
    logic acc;
    logic wr;
    logic rd;
    logic ext_ev;
    logic ovf_ev;
    logic pc_ev;
    logic timer_tick;
    logic core_hit;
    logic periph_hit;
    logic [7:0] ictl_wd;
    logic [7:0] pira_wd;

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] off);
        addr_is = (a == off);
    endfunction

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    // Read data loaded in setup so it stands through the access phase
    assign rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = acc & ~(addr_is(paddr, CIPC_OFF_OPTION)
        | addr_is(paddr, CIPC_OFF_INTCTL) | addr_is(paddr, CIPC_OFF_PIEA)
        | addr_is(paddr, CIPC_OFF_PIRA) | addr_is(paddr, CIPC_OFF_STATUS)
        | addr_is(paddr, CIPC_OFF_LATCH) | addr_is(paddr, CIPC_OFF_PINCHG));
    assign prdata = prdata_reg;

    cipc_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(opt_reg[CIPC_OPT_CLK_SEL]),
        .src_edge(opt_reg[CIPC_OPT_SRC_EDGE]),
        .owner_wdt(opt_reg[CIPC_OPT_OWNER]),
        .rate(opt_reg[CIPC_OPT_RATE_HI:0]),
        .clk_pin(timer_a_clock_pin),
        .wdt_base_tick(wdt_base_tick),
        .timer_tick(timer_tick),
        .wdt_tick(wdt_tick)
    );

    // Event detection
    assign ext_ev = opt_reg[CIPC_OPT_EDGE_SEL] ? (ext_pin & ~ext_d_reg)
                                               : (~ext_pin & ext_d_reg); // see RL2
    assign ovf_ev = timer_tick && (timer_reg == CIPC_ONES8);
    // Mismatch against snapshot, gated by per-pin enables
    assign pc_ev = |((port_b_pins ^ port_snap_reg) & pinchg_reg)
                   | low_power_wake_source; // see RL15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_d_reg <= 1'b0;
        end else begin
            ext_d_reg <= ext_pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_snap_reg <= CIPC_ZERO8;
        end else begin
            port_snap_reg <= port_b_pins;
        end
    end

    // Timer count, writable through the status offset
    always_ff @(posedge pclk) begin
        if (wr && addr_is(paddr, CIPC_OFF_STATUS)) begin
            timer_reg <= pwdata[7:0];
        end else if (timer_tick) begin
            timer_reg <= timer_reg + CIPC_ONE8;
        end
    end // see RL16
    assign timer_a_count = timer_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_reg <= CIPC_OPT_RESET;
        end else if (wr && addr_is(paddr, CIPC_OFF_OPTION)) begin
            opt_reg <= pwdata[7:0];
        end
    end

    // Set wins over a software clear
    assign ictl_wd = (wr && addr_is(paddr, CIPC_OFF_INTCTL))
                     ? pwdata[7:0] : ictl_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ictl_reg <= CIPC_INTCTL_RESET; // see RL20
        end else begin
            ictl_reg <= ictl_wd;
            if (ovf_ev) begin
                ictl_reg[CIPC_IC_TAF] <= 1'b1; // see RL8 RL12
            end
            if (ext_ev) begin
                ictl_reg[CIPC_IC_EXF] <= 1'b1; // see RL13
            end
            if (pc_ev) begin
                ictl_reg[CIPC_IC_PCF] <= 1'b1; // see RL14 RL20
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            piea_reg <= CIPC_PIE_RESET;
        end else if (wr && addr_is(paddr, CIPC_OFF_PIEA)) begin
            piea_reg <= pwdata[7:0] & CIPC_PIE_MASK; // see RL17
        end
    end

    assign pira_wd = (wr && addr_is(paddr, CIPC_OFF_PIRA))
                     ? pwdata[7:0] : pira_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pira_reg <= CIPC_PIE_RESET;
        end else begin
            pira_reg <= (pira_wd | {1'b0, periph_events})
                        & CIPC_PIE_MASK; // see RL8 RL19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= CIPC_ZERO8;
            pinchg_reg <= CIPC_ZERO8;
        end else if (wr && addr_is(paddr, CIPC_OFF_LATCH)) begin
            latch_reg <= pwdata[7:0];
        end else if (wr && addr_is(paddr, CIPC_OFF_PINCHG)) begin
            pinchg_reg <= pwdata[7:0];
        end
    end

    // Pull-ups follow latches unless globally disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pullup_en <= CIPC_ZERO8;
        end else begin
            port_pullup_en <= opt_reg[CIPC_OPT_PULLUP_DIS] ? CIPC_ZERO8
                                                           : latch_reg; // see RL1
        end
    end

    assign core_hit = (ictl_reg[CIPC_IC_TAE] & ictl_reg[CIPC_IC_TAF])
                    | (ictl_reg[CIPC_IC_EXE] & ictl_reg[CIPC_IC_EXF])
                    | (ictl_reg[CIPC_IC_PCE] & ictl_reg[CIPC_IC_PCF]);
    assign periph_hit = ictl_reg[CIPC_IC_PERIPHERAL_IRQ_GATE]
                        & |(piea_reg & pira_reg); // see RL11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= ictl_reg[CIPC_IC_GIE]
                       & (core_hit | periph_hit); // see RL10 RL18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= CIPC_ZERO32;
        end else if (rd) begin
            if (addr_is(paddr, CIPC_OFF_OPTION)) begin
                prdata_reg <= {24'h000000, opt_reg};
            end else if (addr_is(paddr, CIPC_OFF_INTCTL)) begin
                prdata_reg <= {24'h000000, ictl_reg};
            end else if (addr_is(paddr, CIPC_OFF_PIEA)) begin
                prdata_reg <= {24'h000000, piea_reg};
            end else if (addr_is(paddr, CIPC_OFF_PIRA)) begin
                prdata_reg <= {24'h000000, pira_reg};
            end else if (addr_is(paddr, CIPC_OFF_STATUS)) begin
                prdata_reg <= {24'h000000, timer_reg};
            end else if (addr_is(paddr, CIPC_OFF_LATCH)) begin
                prdata_reg <= {24'h000000, latch_reg};
            end else if (addr_is(paddr, CIPC_OFF_PINCHG)) begin
                prdata_reg <= {24'h000000, pinchg_reg};
            end else begin
                prdata_reg <= CIPC_ZERO32;
            end
        end
    end

    // Checks
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    gate_block_a: assert property ( // see RL10
        !ictl_reg[CIPC_IC_GIE] |=> !irq_req)
        else $error("request without global enable");
    periph_gate_a: assert property ( // see RL11
        (!ictl_reg[CIPC_IC_PERIPHERAL_IRQ_GATE] && !core_hit) |=> !irq_req)
        else $error("peripheral request without gate");
    irq_raise_a: assert property ( // see RL18
        (ictl_reg[CIPC_IC_GIE] && core_hit) |=> irq_req)
        else $error("request missing");
    irq_quiet_a: assert property ( // see RL18
        (!core_hit && !periph_hit) |=> !irq_req)
        else $error("request with no enabled flag");
    ovf_flag_a: assert property ( // see RL12
        ovf_ev |=> ictl_reg[CIPC_IC_TAF])
        else $error("overflow flag not set");
    ext_flag_a: assert property ( // see RL13 RL8
        ext_ev |=> ictl_reg[CIPC_IC_EXF])
        else $error("pin flag not set");
    pc_flag_a: assert property ( // see RL14
        pc_ev |=> ictl_reg[CIPC_IC_PCF])
        else $error("change flag not set");
    periph_flag_a: assert property ( // see RL8 RL19
        (|periph_events)
        |=> ((pira_reg[6:0] & $past(periph_events)) == $past(periph_events)))
        else $error("peripheral flag not set");
    pullup_off_a: assert property ( // see RL1
        opt_reg[CIPC_OPT_PULLUP_DIS] |=> port_pullup_en == CIPC_ZERO8)
        else $error("pull-ups on while disabled");
    pullup_follow_a: assert property ( // see RL1
        !opt_reg[CIPC_OPT_PULLUP_DIS] |=> port_pullup_en == $past(latch_reg))
        else $error("pull-ups not following latches");
    pie_top_a: assert property ( // see RL17
        !piea_reg[7] && !pira_reg[7])
        else $error("bit 7 set");
    flag_sticky_a: assert property ( // see RL12
        (ictl_reg[CIPC_IC_TAF] && !wr) |=> ictl_reg[CIPC_IC_TAF])
        else $error("overflow flag dropped");
    ext_sticky_a: assert property ( // see RL13
        (ictl_reg[CIPC_IC_EXF] && !wr) |=> ictl_reg[CIPC_IC_EXF])
        else $error("pin flag dropped");
    pc_sticky_a: assert property ( // see RL14
        (ictl_reg[CIPC_IC_PCF] && !wr) |=> ictl_reg[CIPC_IC_PCF])
        else $error("change flag dropped");
    irq_seen_c: cover property ($rose(irq_req));
    ovf_seen_c: cover property (ovf_ev);
    periph_seen_c: cover property (periph_hit && ictl_reg[CIPC_IC_GIE]);
    ext_seen_c: cover property (ext_ev);
    pc_seen_c: cover property (pc_ev);
endmodule
`default_nettype wire

// file: verilog/cipc_prescaler.sv
// Shared prescaler with Timer0 edge selection and watchdog tick output
`timescale 1ns/1ps
`default_nettype none
module cipc_prescaler (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic clk_sel, // 1 external pin, 0 instruction clock
    input wire logic src_edge, // 1 falling, 0 rising pin edge
    input wire logic owner_wdt, // 1 prescaler to watchdog
    input wire logic [2:0] rate, // Rate field
    input wire logic clk_pin, // External timer clock pin
    input wire logic wdt_base_tick, // Raw watchdog time base tick
    output logic timer_tick, // Timer0 increment pulse
    output logic wdt_tick // Watchdog increment pulse
);
    import cipc_pkg::*;
    logic pin_d_reg;
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic src_ev;
    logic rise;
    logic fall;
    logic pre_in;
    logic pre_out;
    logic [7:0] span;
    logic [7:0] term;

    assign rise = clk_pin & ~pin_d_reg;
    assign fall = ~clk_pin & pin_d_reg;
    // Source and edge pick
    assign src_ev = clk_sel ? (src_edge ? fall : rise) : 1'b1; // see RL3 RL4
    assign pre_in = owner_wdt ? wdt_base_tick : src_ev; // see RL5
    // Terminal count 2^(r+1)-1 for the timer, 2^r-1 for the watchdog
    assign span = CIPC_ONES8 >> (~rate);
    assign term = owner_wdt ? {1'b0, span[7:1]} : span; // see RL6
    assign div_next = (div_reg >= term) ? CIPC_ZERO8 : div_reg + CIPC_ONE8;
    assign pre_out = pre_in && (div_reg >= term);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= clk_pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= CIPC_ZERO8;
        end else if (pre_in) begin
            div_reg <= div_next;
        end
    end

    // Undivided timer when watchdog owns the prescaler
    assign timer_tick = owner_wdt ? src_ev : pre_out; // see RL7
    assign wdt_tick = owner_wdt ? pre_out : wdt_base_tick;
endmodule
`default_nettype wire
